//--- rtl/acf_consts.svh
`ifndef ACF_CONSTS_SVH
`define ACF_CONSTS_SVH

// Register byte offsets (word aligned)
`define ACF_OFS_CON1     12'h000
`define ACF_OFS_CON2     12'h010
`define ACF_OFS_CON3     12'h020
`define ACF_OFS_CHS      12'h030
`define ACF_OFS_SCAN     12'h040
`define ACF_OFS_CON5     12'h050
`define ACF_OFS_HIT      12'h060
`define ACF_OFS_RESULT   12'h070
// Alias sub-offsets within each 16-byte group
`define ACF_ALIAS_CLR    2'd1
`define ACF_ALIAS_SET    2'd2
`define ACF_ALIAS_INV    2'd3

// Control register one field positions
`define ACF_BIT_ON       15
`define ACF_BIT_STOP_IN_IDLE     13
`define ACF_FORM_HI      10
`define ACF_FORM_LO      8
`define ACF_SSRC_HI      7
`define ACF_SSRC_LO      4
`define ACF_BIT_TWELVE_BIT_SELECT   3
`define ACF_BIT_AUTO_SAMPLE_START     2
`define ACF_BIT_SAMPLE_ENABLE     1
`define ACF_BIT_DONE     0
// Threshold-detect enable in control register five
`define ACF_BIT_THRESHOLD_DETECT_ENABLE     15

// Writable masks and reset value
`define ACF_CON1_MASK    32'h0000_a7ff
`define ACF_RESET_VALUE  32'h0000_0000
`define ACF_SCAN_MASK20  32'h7000_07ff
`define ACF_SCAN_MASK28  32'h7000_0fff
`define ACF_SCAN_MASK36  32'h7000_3fff
`define ACF_HIT_MASK20   32'h0000_07ff
`define ACF_HIT_MASK28   32'h0000_0fff
`define ACF_HIT_MASK36   32'h0000_3fff

// Trigger codes
`define ACF_SSRC_MANUAL  4'h0
`define ACF_SSRC_EXT     4'h1
`define ACF_SSRC_AUTO    4'h7

// Converter clock divider in system clocks, conversion length in converter clock periods
`define ACF_TAD_DIV      8'd4
`define ACF_CONV_TADS    5'd14

`endif

//--- rtl/acf_pkg.sv
package acf_pkg;
  typedef enum logic [1:0] {
    ACF_IDLE,
    ACF_SAMPLE,
    ACF_CONVERT
  } acf_state_t;
endpackage : acf_pkg

//--- rtl/acf_formatter.sv
`timescale 1ns/10ps
`default_nettype none
`include "acf_consts.svh"
module acf_formatter import acf_pkg::*; (
  input  wire logic [11:0] raw_in,
  input  wire logic        twelve_bit_select_in,
  input  wire logic [2:0]  form_in,
  output logic      [31:0] word_out
);
  logic [11:0] s12;
  logic [9:0]  s10;

  // Signed forms flip the MSB of the offset-binary code
  assign s12 = {~raw_in[11], raw_in[10:0]};
  assign s10 = {~raw_in[9], raw_in[8:0]};

  // Alignment and widening per format code
  always_comb begin
    word_out = 32'h0000_0000;
    if (twelve_bit_select_in) begin
      case (form_in)
        3'b111:  word_out = {s12, 20'h00000};
        3'b110:  word_out = {raw_in, 20'h00000};
        3'b011:  word_out = {16'h0000, s12, 4'h0};
        3'b010:  word_out = {16'h0000, raw_in, 4'h0};
        default: word_out = {20'h00000, raw_in};
      endcase
    end else begin
      case (form_in)
        3'b111:  word_out = {s10, 22'h000000};
        3'b110:  word_out = {raw_in[9:0], 22'h000000};
        3'b101:  word_out = {{22{s10[9]}}, s10};
        3'b100:  word_out = {22'h000000, raw_in[9:0]};
        3'b011:  word_out = {16'h0000, s10, 6'h00};
        3'b010:  word_out = {16'h0000, raw_in[9:0], 6'h00};
        default: word_out = {22'h000000, raw_in[9:0]};
      endcase
    end
  end
endmodule : acf_formatter
`default_nettype wire

//--- rtl/acf_ctrl.sv
// Contract
// - Converter runs only while enable bit 15 is set.
// - Stop-in-idle bit 13 halts the converter while device is idle.
// - Format field bits 10-8 selects result alignment and widening.
// - 12-bit formats 111/110: signed/unsigned fraction in top of 32 bits.
// - 12-bit formats 011/010: fraction in low 16 bits, upper zero.
// - 10-bit formats 111/110: signed/unsigned fraction left in 32 bits.
// - 10-bit formats 101/100: sign/zero-extended 32-bit integer.
// - 10-bit formats 011/010: fraction in low 16 bits, upper zero.
// - 10-bit format 000: 16-bit unsigned integer, right-justified.
// - Sample-enable held 0 and unwritable while converter disabled.
// - Automatic modes clear done flag when next sampling starts.
// - Software clear of sample-enable no trigger under threshold detect.
// - Alias offsets 0x4/0x8/0xC clear/set/invert written one bits.
// - 20-pin variant: scan and hit bits 13:11 absent, read 0.
// - 28-pin variant: scan and hit bits 13:12 absent, read 0.
// - Control register one bits 31-16 read zero, ignore writes.
// - All control, select, scan and hit registers reset to zero.
// - Resolution bit 3 set selects 12-bit, clear selects 10-bit.
// - Trigger code 0000: software clear of sample-enable converts.
`timescale 1ns/10ps
`default_nettype none
`include "acf_consts.svh"
module acf_ctrl import acf_pkg::*; #(
  parameter int PIN_COUNT = 36
) (
  input  wire logic        clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [11:0] paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        idle_mode_in,
  input  wire logic        ext_trigger_in,
  input  wire logic [11:0] conv_data_in,
  output logic             sampling_out,
  output logic             convert_out,
  output logic      [31:0] result_out,
  output logic             result_valid_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  logic [31:0] con1_q;
  logic [31:0] con2_q;
  logic [31:0] con3_q;
  logic [31:0] chs_q;
  logic [31:0] scan_q;
  logic [31:0] con5_q;
  logic [31:0] hit_q;
  logic [31:0] result_q;
  logic        result_valid_q;
  acf_state_t  state_q;
  logic [7:0]  tad_cnt_q;
  logic [4:0]  conv_cnt_q;
  logic [1:0]  ext_sync_q;
  logic        ext_prev_q;

  logic [31:0] scan_mask;
  logic [31:0] hit_mask;

  // Pin-count variants trim the top scan and hit bits
  assign scan_mask = (PIN_COUNT == 20) ? `ACF_SCAN_MASK20 :
                     (PIN_COUNT == 28) ? `ACF_SCAN_MASK28 :
                                         `ACF_SCAN_MASK36;
  assign hit_mask  = (PIN_COUNT == 20) ? `ACF_HIT_MASK20 :
                     (PIN_COUNT == 28) ? `ACF_HIT_MASK28 :
                                         `ACF_HIT_MASK36;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode: zero-wait, one word per 16-byte group plus three aliases
  logic        wr_acc;
  logic [2:0]  grp;
  logic [1:0]  alias_sel;
  logic        mapped;

  assign grp       = paddr_in[6:4];
  assign alias_sel = paddr_in[3:2];
  assign mapped    = (paddr_in[11:7] == 5'h00) && (paddr_in[1:0] == 2'b00);
  assign wr_acc    = psel_in && penable_in && pwrite_in && mapped;
  assign pready_out  = 1'b1;
  // Unmapped addresses answer with an error, reads return zero
  assign pslverr_out = psel_in && penable_in && !mapped;

  // Alias write merges: plain, clear, set, invert
  function automatic logic [31:0] acf_merge(input logic [31:0] cur,
                                            input logic [31:0] wd,
                                            input logic [1:0]  sel);
    case (sel)
      `ACF_ALIAS_CLR: acf_merge = cur & ~wd;
      `ACF_ALIAS_SET: acf_merge = cur | wd;
      `ACF_ALIAS_INV: acf_merge = cur ^ wd;
      default:        acf_merge = wd;
    endcase
  endfunction : acf_merge

  logic [31:0] con1_wr;
  logic        con1_hit;
  assign con1_hit = wr_acc && (grp == 3'd0);
  assign con1_wr  = acf_merge(con1_q, pwdata_in, alias_sel)
                    & `ACF_CON1_MASK;

  ////////////////////////////////////////////////////////////////////////////
  // Field views
  logic       on_bit;
  logic       run_en;
  logic [3:0] ssrc;
  logic       auto_sample_start;
  logic       threshold_detect_enable;

  assign on_bit = con1_q[`ACF_BIT_ON];
  // Idle halts only when stop-in-idle is set
  assign run_en = on_bit &&
                  !(con1_q[`ACF_BIT_STOP_IN_IDLE] && idle_mode_in);
  assign ssrc   = con1_q[`ACF_SSRC_HI:`ACF_SSRC_LO];
  assign auto_sample_start   = con1_q[`ACF_BIT_AUTO_SAMPLE_START];
  assign threshold_detect_enable   = con5_q[`ACF_BIT_THRESHOLD_DETECT_ENABLE];

  ////////////////////////////////////////////////////////////////////////////
  // External trigger pin synchroniser and edge detect
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ext_sync_q <= 2'b00;
      ext_prev_q <= 1'b0;
    end else begin
      ext_sync_q <= {ext_sync_q[0], ext_trigger_in};
      ext_prev_q <= ext_sync_q[1];
    end
  end

  logic ext_edge;
  assign ext_edge = ext_sync_q[1] && !ext_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Converter clock divider: one-cycle enable per period
  logic tad_tick;
  assign tad_tick = (tad_cnt_q == `ACF_TAD_DIV - 8'd1);

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tad_cnt_q <= 8'h00;
    end else if (!run_en || tad_tick) begin
      tad_cnt_q <= 8'h00;
    end else begin
      tad_cnt_q <= tad_cnt_q + 8'd1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer decisions
  logic sw_sample_enable_clear;
  logic trigger;
  logic start_sample;
  logic conv_done;

  // Software clearing sample-enable, masked under threshold detect
  assign sw_sample_enable_clear = con1_hit && con1_q[`ACF_BIT_SAMPLE_ENABLE] &&
                         !con1_wr[`ACF_BIT_SAMPLE_ENABLE] && !threshold_detect_enable;

  always_comb begin
    case (ssrc)
      `ACF_SSRC_MANUAL: trigger = sw_sample_enable_clear;
      `ACF_SSRC_EXT:    trigger = ext_edge;
      `ACF_SSRC_AUTO:   trigger = tad_tick;
      default:          trigger = 1'b0;
    endcase
  end

  // Auto-sample restarts as soon as the sequencer rests in idle
  assign start_sample = (state_q == ACF_IDLE) && run_en &&
                        (auto_sample_start || (con1_hit && con1_wr[`ACF_BIT_SAMPLE_ENABLE]));
  assign conv_done    = (state_q == ACF_CONVERT) && tad_tick &&
                        (conv_cnt_q == `ACF_CONV_TADS - 5'd1);

  // Manual sample time above 3 CONVERTER_CLOCK_PERIOD is software's duty; not checked here
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_q    <= ACF_IDLE;
      conv_cnt_q <= 5'd0;
    end else if (!run_en) begin
      state_q    <= ACF_IDLE;
      conv_cnt_q <= 5'd0;
    end else begin
      case (state_q)
        ACF_IDLE: begin
          conv_cnt_q <= 5'd0;
          if (start_sample) begin
            state_q <= ACF_SAMPLE;
          end
        end
        ACF_SAMPLE: begin
          if (trigger) begin
            state_q <= ACF_CONVERT;
          end
        end
        ACF_CONVERT: begin
          if (conv_done) begin
            state_q <= ACF_IDLE;
          end else if (tad_tick) begin
            conv_cnt_q <= conv_cnt_q + 5'd1;
          end
        end
        default: begin
          state_q <= ACF_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register one with hardware-owned sample and done bits
  logic sample_enable_d;
  logic done_d;

  always_comb begin
    sample_enable_d = con1_hit ? con1_wr[`ACF_BIT_SAMPLE_ENABLE] : con1_q[`ACF_BIT_SAMPLE_ENABLE];
    done_d = con1_hit ? con1_wr[`ACF_BIT_DONE] : con1_q[`ACF_BIT_DONE];
    if (state_q == ACF_SAMPLE && trigger) begin
      sample_enable_d = 1'b0;
    end
    if (start_sample) begin
      sample_enable_d = 1'b1;
      if (auto_sample_start) begin
        done_d = 1'b0;
      end
    end
    // Hardware set wins over a same-cycle software clear
    if (conv_done) begin
      done_d = 1'b1;
    end
    if (!on_bit || (con1_hit && !con1_wr[`ACF_BIT_ON])) begin
      sample_enable_d = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      con1_q <= `ACF_RESET_VALUE;
    end else begin
      if (con1_hit) begin
        con1_q[15:2] <= con1_wr[15:2];
      end
      con1_q[`ACF_BIT_SAMPLE_ENABLE] <= sample_enable_d;
      con1_q[`ACF_BIT_DONE] <= done_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Other control registers: plain storage with alias access
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      con2_q <= `ACF_RESET_VALUE;
      con3_q <= `ACF_RESET_VALUE;
      chs_q  <= `ACF_RESET_VALUE;
      scan_q <= `ACF_RESET_VALUE;
      con5_q <= `ACF_RESET_VALUE;
      hit_q  <= `ACF_RESET_VALUE;
    end else if (wr_acc) begin
      case (grp)
        3'd1: con2_q <= acf_merge(con2_q, pwdata_in, alias_sel);
        3'd2: con3_q <= acf_merge(con3_q, pwdata_in, alias_sel);
        3'd3: chs_q  <= acf_merge(chs_q, pwdata_in, alias_sel);
        3'd4: scan_q <= acf_merge(scan_q, pwdata_in, alias_sel)
                        & scan_mask;
        3'd5: con5_q <= acf_merge(con5_q, pwdata_in, alias_sel);
        3'd6: hit_q  <= acf_merge(hit_q, pwdata_in, alias_sel)
                        & hit_mask;
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Result formatting and capture
  logic [31:0] fmt_word;

  acf_formatter u_fmt (
    .raw_in    (conv_data_in),
    .twelve_bit_select_in (con1_q[`ACF_BIT_TWELVE_BIT_SELECT]),
    .form_in   (con1_q[`ACF_FORM_HI:`ACF_FORM_LO]),
    .word_out  (fmt_word)
  );

  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      result_q       <= 32'h0000_0000;
      result_valid_q <= 1'b0;
    end else begin
      result_valid_q <= conv_done;
      if (conv_done) begin
        result_q <= fmt_word;
      end
    end
  end

  assign result_out       = result_q;
  assign result_valid_out = result_valid_q;
  assign sampling_out     = (state_q == ACF_SAMPLE);
  assign convert_out      = (state_q == ACF_CONVERT);

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; alias addresses read the base register
  always_comb begin
    prdata_out = 32'h0000_0000;
    if (psel_in && !pwrite_in && mapped) begin
      case (grp)
        3'd0: prdata_out = con1_q & `ACF_CON1_MASK;
        3'd1: prdata_out = con2_q;
        3'd2: prdata_out = con3_q;
        3'd3: prdata_out = chs_q;
        3'd4: prdata_out = scan_q & scan_mask;
        3'd5: prdata_out = con5_q;
        3'd6: prdata_out = hit_q & hit_mask;
        3'd7: prdata_out = result_q;
        default: prdata_out = 32'h0000_0000;
      endcase
    end
  end

endmodule : acf_ctrl
`default_nettype wire

//--- tb/acf_ctrl_chk.sv
`timescale 1ns/10ps
`default_nettype none
module acf_ctrl_chk #(
  parameter int PIN_COUNT = 36
) (
  input wire logic        clk_in,
  input wire logic        arst_n_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        idle_mode_in,
  input wire logic        ext_trigger_in,
  input wire logic [11:0] conv_data_in,
  input wire logic        sampling_out,
  input wire logic        convert_out,
  input wire logic [31:0] result_out,
  input wire logic        result_valid_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);
  logic       conv_prev_q;
  logic [7:0] conv_cnt_q;
  logic       rd_q;
  assign rd_q = psel_in && !pwrite_in;
  ////////////////////////////////////////////////////////////////////////////
  // Length of the latest convert run, held after it ends
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      conv_prev_q <= 1'b0;
      conv_cnt_q  <= 8'h00;
    end else begin
      conv_prev_q <= convert_out;
      if (convert_out) conv_cnt_q <= conv_prev_q ? conv_cnt_q + 8'h01 : 8'h01;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Free-running tick phase makes the run 53 to 56 cycles
  property p_slverr;
    psel_in && penable_in |->
      pslverr_out == (paddr_in[11:7] != 5'h00 || paddr_in[1:0] != 2'h0);
  endproperty
  a_slverr: assert property (p_slverr) else $error("slverr wrong");
  property p_excl;
    !(sampling_out && convert_out);
  endproperty
  a_excl: assert property (p_excl) else $error("sample and convert");
  property p_conv_len;
    result_valid_out |-> conv_cnt_q inside {[8'd53:8'd57]};
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conv length");
  property p_pulse;
    result_valid_out |=> !result_valid_out;
  endproperty
  a_pulse: assert property (p_pulse) else $error("valid not a pulse");
  property p_hold;
    !result_valid_out |-> $stable(result_out);
  endproperty
  a_hold: assert property (p_hold) else $error("result moved");
  property p_upper;
    rd_q && paddr_in == 12'h000 |-> prdata_out[31:16] == 16'h0000
      && !prdata_out[14] && prdata_out[12:11] == 2'b00;
  endproperty
  a_upper: assert property (p_upper) else $error("unused bits set");
  property p_off;
    psel_in && penable_in && pwrite_in && paddr_in == 12'h000 &&
      !pwdata_in[15] |-> ##[1:2] (!sampling_out && !convert_out);
  endproperty
  a_off: assert property (p_off) else $error("runs while off");
  property p_pins20;
    PIN_COUNT == 20 && rd_q && paddr_in[11:4] inside {8'h04, 8'h06}
      |-> prdata_out[13:11] == 3'b000;
  endproperty
  a_pins20: assert property (p_pins20) else $error("absent bits set");
  property p_pins28;
    PIN_COUNT == 28 && rd_q && paddr_in[11:4] inside {8'h04, 8'h06}
      |-> prdata_out[13:12] == 2'b00;
  endproperty
  a_pins28: assert property (p_pins28) else $error("absent bits set");
  c_result: cover property (result_valid_out);
  c_err: cover property (pslverr_out);
  c_conv: cover property ($rose(convert_out));
endmodule : acf_ctrl_chk
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  localparam int PIN_COUNT = 20;
  // Format codes exercised per resolution; others fall back to raw
  localparam logic [7:0] FORMS12 = 8'hcc;
  localparam logic [7:0] FORMS10 = 8'hfd;
  logic        clk_in    = 1'b0;
  logic        arst_n_in = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        idle = 1'b0, trig = 1'b0;
  logic [11:0] paddr = 12'h000, raw = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, result, rd;
  logic        pready, pslverr, smp, cnv, valid, err;
  int          mismatches = 0, checked = 0, nvalid = 0, n;
  acf_ctrl #(.PIN_COUNT(PIN_COUNT)) dut_u (.clk_in(clk_in),
    .arst_n_in(arst_n_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .idle_mode_in(idle), .ext_trigger_in(trig), .conv_data_in(raw),
    .sampling_out(smp), .convert_out(cnv), .result_out(result),
    .result_valid_out(valid));
  ////////////////////////////////////////////////////////////////////////////
  // Clock and result pulse counter
  initial forever #4 clk_in = ~clk_in;
  always @(posedge clk_in) if (valid === 1'b1) nvalid <= nvalid + 1;
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict
  task automatic cmp_w(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t word %h expected %h", $time, g, e);
    end
  endtask : cmp_w
  task automatic cmp_b(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t flag %b expected %b", $time, g, e);
    end
  endtask : cmp_b
  // Request held until pready is seen high with penable
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_in);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk_in);
    penable <= 1'b1;
    do begin
      @(posedge clk_in);
      k++;
    end while (pready !== 1'b1 && k < 50);
    // A missing answer is a failure, never a silent pass
    if (pready !== 1'b1) begin
      mismatches++;
      $display("[ERR] %0t no pready", $time);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    cmp_w(rd, e);
  endtask : rdc
  task automatic wait_v(input int k);
    int i;
    i = 0;
    while (nvalid < k && i < 200) begin
      @(posedge clk_in);
      i++;
    end
    cmp_b(nvalid >= k, 1'b1);
  endtask : wait_v
  // Offset-binary raw code: signed forms invert the top bit
  function automatic logic [31:0] fmt(input logic m, input logic [2:0] f);
    logic [9:0] t;
    t = raw[9:0];
    case ({m, f})
      4'hf: fmt = {~raw[11], raw[10:0], 20'h0};
      4'he: fmt = {raw, 20'h0};
      4'hb: fmt = {16'h0, ~raw[11], raw[10:0], 4'h0};
      4'ha: fmt = {16'h0, raw, 4'h0};
      4'h7: fmt = {~t[9], t[8:0], 22'h0};
      4'h6: fmt = {t, 22'h0};
      4'h5: fmt = {{22{~t[9]}}, ~t[9], t[8:0]};
      4'h3: fmt = {16'h0, ~t[9], t[8:0], 6'h0};
      4'h2: fmt = {16'h0, t, 6'h0};
      default: fmt = {22'h0, t};
    endcase
  endfunction : fmt
  // Manual sample, software-ended, then result and done check
  task automatic conv(input logic m, input logic [2:0] f);
    logic [31:0] c;
    c = 32'h8000 | (32'(f) << 8) | (32'(m) << 3);
    n = nvalid;
    apb(1'b1, 12'h000, c);
    apb(1'b1, 12'h008, 32'h2);
    repeat (16) @(posedge clk_in);
    cmp_b(smp, 1'b1);
    apb(1'b1, 12'h004, 32'h2);
    wait_v(n + 1);
    cmp_w(result, fmt(m, f));
    rdc(12'h000, c | 32'h1);
  endtask : conv
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_in);
    arst_n_in <= 1'b1;
    for (int a = 0; a < 7; a++) rdc(12'(a * 16), 32'h0);
    apb(1'b1, 12'h000, 32'hffff_7fff);
    rdc(12'h000, 32'h0000_27fd);
    apb(1'b1, 12'h004, 32'hffff_ffff);
    apb(1'b1, 12'h008, 32'hffff_2102);
    rdc(12'h000, 32'h0000_2100);
    apb(1'b1, 12'h00c, 32'h0000_0300);
    rdc(12'h000, 32'h0000_2200);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h040, 32'hffff_ffff);
    rdc(12'h040, 32'h7000_07ff);
    apb(1'b1, 12'h068, 32'hffff_ffff);
    rdc(12'h060, 32'h0000_07ff);
    apb(1'b1, 12'h080, 32'h1);
    cmp_b(err, 1'b1);
    rdc(12'h002, 32'h0);
    cmp_b(err, 1'b1);
    for (int r = 0; r < 2; r++)
      for (int m = 0; m < 2; m++)
        for (int f = 0; f < 8; f++)
          if (m ? FORMS12[f] : FORMS10[f]) begin
            raw <= r ? 12'h15c : 12'ha5c;
            conv(m[0], f[2:0]);
          end
    // Disable in mid-conversion
    apb(1'b1, 12'h000, 32'h8000);
    apb(1'b1, 12'h008, 32'h2);
    repeat (16) @(posedge clk_in);
    apb(1'b1, 12'h004, 32'h2);
    repeat (8) @(posedge clk_in);
    cmp_b(cnv, 1'b1);
    n = nvalid;
    apb(1'b1, 12'h000, 32'h0);
    repeat (2) @(posedge clk_in);
    cmp_b(cnv, 1'b0);
    repeat (80) @(posedge clk_in);
    cmp_b(nvalid == n, 1'b1);
    // Threshold detect blocks the software trigger
    apb(1'b1, 12'h050, 32'h8000);
    apb(1'b1, 12'h000, 32'h8000);
    apb(1'b1, 12'h008, 32'h2);
    repeat (16) @(posedge clk_in);
    apb(1'b1, 12'h004, 32'h2);
    repeat (8) @(posedge clk_in);
    cmp_b(cnv, 1'b0);
    apb(1'b1, 12'h050, 32'h0);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h008, 32'h2);
    rdc(12'h000, 32'h0);
    cmp_b(smp, 1'b0);
    // Idle with and without stop-in-idle
    idle <= 1'b1;
    apb(1'b1, 12'h000, 32'ha000);
    apb(1'b1, 12'h008, 32'h2);
    repeat (4) @(posedge clk_in);
    cmp_b(smp, 1'b0);
    apb(1'b1, 12'h000, 32'h8000);
    apb(1'b1, 12'h008, 32'h2);
    repeat (4) @(posedge clk_in);
    cmp_b(smp, 1'b1);
    idle <= 1'b0;
    // Auto-sample with pin trigger: done cleared as sampling restarts
    // Park the sequencer first so the mode change is no software trigger
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h000, 32'h8014);
    n = nvalid;
    trig <= 1'b1;
    repeat (4) @(posedge clk_in);
    trig <= 1'b0;
    wait_v(n + 1);
    repeat (8) @(posedge clk_in);
    cmp_b(smp, 1'b1);
    apb(1'b0, 12'h000, 32'h0);
    cmp_b(rd[0], 1'b0);
    // Internal counter trigger: two results back to back
    apb(1'b1, 12'h000, 32'h8074);
    n = nvalid;
    wait_v(n + 2);
    apb(1'b1, 12'h000, 32'h0);
    give_verdict();
  end
  // Watchdog well beyond the expected run of a few thousand cycles
  initial begin
    repeat (20000) @(posedge clk_in);
    mismatches++;
    give_verdict();
  end
endmodule : tb_top
bind acf_ctrl acf_ctrl_chk #(.PIN_COUNT(PIN_COUNT)) chk_u (.clk_in,
  .arst_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
  .prdata_out, .pready_out, .pslverr_out, .idle_mode_in, .ext_trigger_in,
  .conv_data_in, .sampling_out, .convert_out, .result_out,
  .result_valid_out);
`default_nettype wire
